// ===== logic/qdl_consts.vh
// constants of the quick channel trigger and link logic
// assumes inclusion by bare name
`ifndef QDL_CONSTS_VH
`define QDL_CONSTS_VH

// ************************************************************
// entry geometry, channel count, queue depth
// ************************************************************
`define QDL_WORDS_PER_ENTRY 8
`define QDL_WORD_W          32
`define QDL_NUM_CH          4
`define QDL_Q_DEPTH         4

// ************************************************************
// control register indexes (address top bit set)
// ************************************************************
`define QDL_MAP0_IDX        4'h0
`define QDL_PEND_IDX        4'h4
`define QDL_SEC_IDX         4'h5
`define QDL_DONE_IDX        4'h6

// ************************************************************
// map register fields and reset values
// ************************************************************
`define QDL_MAP_TRW_LSB     2
`define QDL_MAP_TRW_W       3
`define QDL_MAP_ENT_LSB     5
`define QDL_MAP_TRW_RST     3'h7

// ************************************************************
// entry word fields
// ************************************************************
`define QDL_OPT_WORD        3'h0
`define QDL_OPT_STATIC_BIT  3
`define QDL_LINK_WORD       3'h5
`define QDL_LINK_W          16
`define QDL_LINK_NULL       16'hFFFF
`define QDL_LINK_ENT_LSB    5

`endif

// ===== logic/qdl_parameter_memory_mem.v
// parameter entry word memory, registered read data
// assumes one write and one read per cycle at most
`timescale 1ns/1ps
module qdl_parameter_memory_mem #(
    parameter AW = 10,
    parameter DW = 32
) (
    // clock and enable
    input  wire          ref_clk_in,
    input  wire          ce_in,
    // write port
    input  wire          we_in,
    input  wire [AW-1:0] waddr_in,
    input  wire [DW-1:0] wdata_in,
    // read port
    input  wire          re_in,
    input  wire [AW-1:0] raddr_in,
    output reg  [DW-1:0] rdata_out
);
    reg [DW-1:0] mem_reg [0:(1<<AW)-1];

    // rdata holds between reads; the engine relies on that
    always @(posedge ref_clk_in) begin
        if (ce_in) begin
            if (we_in) begin
                mem_reg[waddr_in] <= wdata_in;
            end
            if (re_in) begin
                rdata_out <= mem_reg[raddr_in];
            end
        end
    end
endmodule

// ===== logic/qdl_idx_fifo.v
// small queue of channel indexes
// assumes DEPTH is a power of two and AW = log2(DEPTH)
`timescale 1ns/1ps
module qdl_idx_fifo #(
    parameter WIDTH = 2,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // clock, reset, enable
    input  wire             ref_clk_in,
    input  wire             srst_in,
    input  wire             ce_in,
    // fill side
    input  wire             in_valid_in,
    output wire             in_ready_out,
    input  wire [WIDTH-1:0] in_data_in,
    // drain side
    output wire             out_valid_out,
    input  wire             out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] slot_reg [0:DEPTH-1];
    reg [AW:0]      wr_ptr_reg;
    reg [AW:0]      rd_ptr_reg;
    wire            full;
    wire            empty;
    wire            push;
    wire            pop;

    assign full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                   (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign empty = (wr_ptr_reg == rd_ptr_reg);
    assign in_ready_out  = ~full;
    assign out_valid_out = ~empty;
    assign out_data_out  = slot_reg[rd_ptr_reg[AW-1:0]];
    assign push = in_valid_in & ~full;
    assign pop  = out_ready_in & ~empty;

    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            wr_ptr_reg <= {(AW+1){1'b0}};
            rd_ptr_reg <= {(AW+1){1'b0}};
        end else if (ce_in) begin
            if (push) begin
                slot_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule

// ===== logic/qdl_quick_channel.v
// quick channel trigger, queue, submission and link reload logic
// assumes a same-clock transfer controller and a one-cycle reg port
//
// How it works
// - each entry is eight 32-bit words in parameter memory
// - the queue holds only channel indexes, never entry contents
// - entry words are read only when the request is submitted
// - four channels, up to four requests outstanding together
// - each channel map register picks any entry by index
// - map register trigger field picks one of the eight words
// - a software write to the trigger word raises a request
// - linking applies unless static or the null link stops it, there is no disable
// - on completion the entry is reloaded from its link entry
// - link FFFFh ends the chain, no reload, with static set or clear
// - static set leaves the entry untouched and skips linking
`timescale 1ns/1ps
`include "qdl_consts.vh"
module qdl_quick_channel #(
    parameter ENTRY_W = 7
) (
    // clock, reset, enable
    input  wire                 ref_clk_in,
    input  wire                 srst_in,
    input  wire                 ce_in,
    // register port
    input  wire [ENTRY_W+3:0]   addr_in,
    input  wire [31:0]          wr_data_in,
    input  wire                 wr_in,
    input  wire                 rd_in,
    output wire [31:0]          rd_data_out,
    // request to transfer controller
    output wire                 tc_valid_out,
    input  wire                 tc_ready_in,
    output wire [1:0]           tc_chan_out,
    output wire [ENTRY_W-1:0]   tc_entry_out,
    output wire [255:0]         tc_ctx_out,
    // completion from transfer controller
    input  wire                 tc_done_in,
    input  wire [1:0]           tc_done_chan_in
);
    localparam AW   = ENTRY_W + 3;
    localparam NCH  = `QDL_NUM_CH;
    localparam WW   = `QDL_WORD_W;
    localparam TRWW = `QDL_MAP_TRW_W;

    localparam ST_IDLE      = 3'd0;
    localparam ST_SUB_RD    = 3'd1;
    localparam ST_SUB_OFFER = 3'd2;
    localparam ST_LNK_RD    = 3'd3;
    localparam ST_LNK_CHK   = 3'd4;
    localparam ST_CPY_RD    = 3'd5;
    localparam ST_CPY_WR    = 3'd6;

    // ********************************************************
    // register port decode
    // ********************************************************
    wire               sel_ctrl;
    wire [3:0]         ctrl_idx;
    wire [ENTRY_W-1:0] wr_ent;
    wire [2:0]         wr_word;

    assign sel_ctrl = addr_in[ENTRY_W+3];
    assign ctrl_idx = addr_in[3:0];
    assign wr_ent   = addr_in[ENTRY_W+2:3];
    assign wr_word  = addr_in[2:0];

    reg [ENTRY_W-1:0] map_ent_reg [0:NCH-1];
    reg [TRWW-1:0]    map_trw_reg [0:NCH-1];
    reg [NCH-1:0]     pend_reg;
    reg [NCH-1:0]     sec_reg;
    reg [NCH-1:0]     done_reg;
    reg [31:0]        ctrl_rdata_reg;
    reg               rd_mem_reg;

    // ********************************************************
    // engine registers
    // ********************************************************
    reg [2:0]          state_reg;
    reg [3:0]          wcnt_reg;
    reg [2:0]          rd_word_reg;
    reg                rd_pend_reg;
    reg [1:0]          ch_reg;
    reg [ENTRY_W-1:0]  dst_ent_reg;
    reg [ENTRY_W-1:0]  src_ent_reg;
    reg [255:0]        ctx_reg;
    reg                static_reg;
    reg [`QDL_LINK_W-1:0] link_reg;

    // ********************************************************
    // trigger match and queue admission
    // ********************************************************
    reg [NCH-1:0] trig;
    reg [NCH-1:0] push_set;
    reg [1:0]     push_ch;
    reg           push_any;
    reg [1:0]     done_ch;
    reg           done_any;
    integer       i;

    wire          q_in_ready;
    wire          q_out_valid;
    wire [1:0]    q_out_data;
    wire          q_pop;

    always @* begin
        trig     = {NCH{1'b0}};
        push_set = {NCH{1'b0}};
        push_ch  = 2'd0;
        push_any = 1'b0;
        done_ch  = 2'd0;
        done_any = 1'b0;
        for (i = 0; i < NCH; i = i + 1) begin
            // reload writes never trigger
            trig[i] = wr_in && !sel_ctrl &&
                      (wr_ent == map_ent_reg[i]) &&
                      (wr_word == map_trw_reg[i]);
        end
        for (i = NCH - 1; i >= 0; i = i - 1) begin
            // a queued channel waits; one slot each
            if (pend_reg[i] && !sec_reg[i]) begin
                push_ch  = i[1:0];
                push_any = 1'b1;
            end
            if (done_reg[i]) begin
                done_ch  = i[1:0];
                done_any = 1'b1;
            end
        end
        if (push_any && q_in_ready) begin
            push_set[push_ch] = 1'b1;
        end
    end

    // index-only queue; contents stay in memory
    qdl_idx_fifo #(
        .WIDTH (2),
        .DEPTH (`QDL_Q_DEPTH),
        .AW    (2)
    ) u_queue (
        .ref_clk_in    (ref_clk_in),
        .srst_in       (srst_in),
        .ce_in         (ce_in),
        .in_valid_in   (push_any),
        .in_ready_out  (q_in_ready),
        .in_data_in    (push_ch),
        .out_valid_out (q_out_valid),
        .out_ready_in  (q_pop),
        .out_data_out  (q_out_data)
    );

    // ********************************************************
    // memory arbitration: software always wins, engine stalls
    // ********************************************************
    reg           eng_re;
    reg [AW-1:0]  eng_raddr;
    reg           eng_we_req;
    wire          eng_grant;
    wire          eng_we;
    wire          mem_re;
    wire [AW-1:0] mem_raddr;
    wire          mem_we;
    wire [AW-1:0] mem_waddr;
    wire [WW-1:0] mem_wdata;
    wire [WW-1:0] mem_rdata;
    wire          sw_mem_rd;

    assign sw_mem_rd = rd_in && !sel_ctrl;
    assign eng_grant = eng_re && !rd_in;
    assign eng_we    = eng_we_req && !wr_in;
    assign mem_re    = sw_mem_rd || eng_grant;
    assign mem_raddr = sw_mem_rd ? addr_in[AW-1:0] : eng_raddr;
    assign mem_we    = (wr_in && !sel_ctrl) || eng_we;
    assign mem_waddr = eng_we ? {dst_ent_reg, wcnt_reg[2:0]}
                              : addr_in[AW-1:0];
    assign mem_wdata = eng_we ? mem_rdata : wr_data_in;

    qdl_parameter_memory_mem #(
        .AW (AW),
        .DW (WW)
    ) u_mem (
        .ref_clk_in (ref_clk_in),
        .ce_in      (ce_in),
        .we_in      (mem_we),
        .waddr_in   (mem_waddr),
        .wdata_in   (mem_wdata),
        .re_in      (mem_re),
        .raddr_in   (mem_raddr),
        .rdata_out  (mem_rdata)
    );

    always @* begin
        eng_re     = 1'b0;
        eng_raddr  = {AW{1'b0}};
        eng_we_req = 1'b0;
        case (state_reg)
            ST_SUB_RD: begin
                eng_re    = !wcnt_reg[3];
                eng_raddr = {dst_ent_reg, wcnt_reg[2:0]};
            end
            ST_LNK_RD: begin
                eng_re    = (wcnt_reg < 4'd2);
                eng_raddr = {dst_ent_reg, (wcnt_reg == 4'd0) ?
                             `QDL_OPT_WORD : `QDL_LINK_WORD};
            end
            ST_CPY_RD: begin
                eng_re    = 1'b1;
                eng_raddr = {src_ent_reg, wcnt_reg[2:0]};
            end
            ST_CPY_WR: begin
                eng_we_req = 1'b1;
            end
            default: begin
                eng_re = 1'b0;
            end
        endcase
    end

    // ********************************************************
    // submission and reload sequencer
    // ********************************************************
    wire [ENTRY_W-1:0] link_ent;
    wire [NCH-1:0]     sub_clr;
    wire [NCH-1:0]     done_clr;
    wire [NCH-1:0]     done_set;
    wire               link_stop;

    assign q_pop     = (state_reg == ST_SUB_OFFER) && tc_ready_in;
    assign sub_clr   = q_pop ? ({{(NCH-1){1'b0}}, 1'b1} << ch_reg)
                             : {NCH{1'b0}};
    assign done_clr  = (state_reg == ST_IDLE && done_any) ?
                       ({{(NCH-1){1'b0}}, 1'b1} << done_ch)
                       : {NCH{1'b0}};
    assign done_set  = tc_done_in ?
                       ({{(NCH-1){1'b0}}, 1'b1} << tc_done_chan_in)
                       : {NCH{1'b0}};
    assign link_ent  = link_reg[`QDL_LINK_ENT_LSB+ENTRY_W-1:
                                `QDL_LINK_ENT_LSB];
    // linking has no enable; only static or the null link stops it
    assign link_stop = static_reg ||
                       (link_reg == `QDL_LINK_NULL);

    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            state_reg   <= ST_IDLE;
            wcnt_reg    <= 4'd0;
            rd_word_reg <= 3'd0;
            rd_pend_reg <= 1'b0;
            ch_reg      <= 2'd0;
            dst_ent_reg <= {ENTRY_W{1'b0}};
            src_ent_reg <= {ENTRY_W{1'b0}};
            ctx_reg     <= 256'd0;
            static_reg  <= 1'b0;
            link_reg    <= {`QDL_LINK_W{1'b0}};
        end else if (ce_in) begin
            rd_pend_reg <= eng_grant;
            if (eng_grant) begin
                rd_word_reg <= eng_raddr[2:0];
                wcnt_reg    <= wcnt_reg + 4'd1;
            end
            case (state_reg)
                ST_IDLE: begin
                    wcnt_reg <= 4'd0;
                    // pending reloads go first so a queued submit
                    // of the same channel sees the reloaded entry
                    if (done_any) begin
                        ch_reg      <= done_ch;
                        dst_ent_reg <= map_ent_reg[done_ch];
                        state_reg   <= ST_LNK_RD;
                    end else if (q_out_valid) begin
                        ch_reg      <= q_out_data;
                        dst_ent_reg <= map_ent_reg[q_out_data];
                        state_reg   <= ST_SUB_RD;
                    end
                end
                ST_SUB_RD: begin
                    if (rd_pend_reg) begin
                        ctx_reg[rd_word_reg*WW +: WW] <= mem_rdata;
                        if (rd_word_reg == 3'd7) begin
                            state_reg <= ST_SUB_OFFER;
                        end
                    end
                end
                ST_SUB_OFFER: begin
                    if (tc_ready_in) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_LNK_RD: begin
                    if (rd_pend_reg) begin
                        if (rd_word_reg == `QDL_OPT_WORD) begin
                            static_reg <=
                                mem_rdata[`QDL_OPT_STATIC_BIT];
                        end else begin
                            link_reg  <= mem_rdata[`QDL_LINK_W-1:0];
                            state_reg <= ST_LNK_CHK;
                        end
                    end
                end
                ST_LNK_CHK: begin
                    wcnt_reg    <= 4'd0;
                    src_ent_reg <= link_ent;
                    if (link_stop) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        state_reg <= ST_CPY_RD;
                    end
                end
                ST_CPY_RD: begin
                    if (eng_grant) begin
                        // count advances after the write
                        wcnt_reg  <= wcnt_reg;
                        state_reg <= ST_CPY_WR;
                    end
                end
                ST_CPY_WR: begin
                    if (eng_we) begin
                        wcnt_reg <= wcnt_reg + 4'd1;
                        if (wcnt_reg == 4'd7) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            state_reg <= ST_CPY_RD;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ********************************************************
    // map registers, status bits, read data
    // ********************************************************
    integer k;

    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            for (k = 0; k < NCH; k = k + 1) begin
                map_ent_reg[k] <= {ENTRY_W{1'b0}};
                map_trw_reg[k] <= `QDL_MAP_TRW_RST;
            end
            pend_reg       <= {NCH{1'b0}};
            sec_reg        <= {NCH{1'b0}};
            done_reg       <= {NCH{1'b0}};
            ctrl_rdata_reg <= 32'h0000_0000;
            rd_mem_reg     <= 1'b0;
        end else if (ce_in) begin
            for (k = 0; k < NCH; k = k + 1) begin
                if (wr_in && sel_ctrl &&
                    ctrl_idx == (`QDL_MAP0_IDX + k)) begin
                    map_ent_reg[k] <= wr_data_in[`QDL_MAP_ENT_LSB+
                                      ENTRY_W-1:`QDL_MAP_ENT_LSB];
                    map_trw_reg[k] <= wr_data_in[`QDL_MAP_TRW_LSB+
                                      TRWW-1:`QDL_MAP_TRW_LSB];
                end
            end
            // set wins over clear on every status bit
            pend_reg <= (pend_reg & ~push_set) | trig;
            sec_reg  <= (sec_reg & ~sub_clr) | push_set;
            done_reg <= (done_reg & ~done_clr) | done_set;
            rd_mem_reg     <= sw_mem_rd;
            ctrl_rdata_reg <= 32'h0000_0000;
            if (rd_in && sel_ctrl) begin
                if (ctrl_idx < (`QDL_MAP0_IDX + NCH)) begin
                    ctrl_rdata_reg[`QDL_MAP_ENT_LSB+ENTRY_W-1:
                                   `QDL_MAP_ENT_LSB] <=
                        map_ent_reg[ctrl_idx[1:0]];
                    ctrl_rdata_reg[`QDL_MAP_TRW_LSB+TRWW-1:
                                   `QDL_MAP_TRW_LSB] <=
                        map_trw_reg[ctrl_idx[1:0]];
                end else if (ctrl_idx == `QDL_PEND_IDX) begin
                    ctrl_rdata_reg[NCH-1:0] <= pend_reg;
                end else if (ctrl_idx == `QDL_SEC_IDX) begin
                    ctrl_rdata_reg[NCH-1:0] <= sec_reg;
                end else if (ctrl_idx == `QDL_DONE_IDX) begin
                    ctrl_rdata_reg[NCH-1:0] <= done_reg;
                end
            end
        end
    end

    assign rd_data_out  = rd_mem_reg ? mem_rdata : ctrl_rdata_reg;
    assign tc_valid_out = (state_reg == ST_SUB_OFFER);
    assign tc_chan_out  = ch_reg;
    assign tc_entry_out = dst_ent_reg;
    assign tc_ctx_out   = ctx_reg;
endmodule

// ===== verif/qdl_qc_asserts.sv
// port-level assertions for the quick channel block
// assumes a bind from the bench top and one clock
`timescale 1ns/1ps
module qdl_qc_asserts #(
    parameter ENTRY_W = 7
) (
    // clock, reset, enable
    input wire               ref_clk_in,
    input wire               srst_in,
    input wire               ce_in,
    // register port
    input wire [ENTRY_W+3:0] addr_in,
    input wire [31:0]        wr_data_in,
    input wire               wr_in,
    input wire               rd_in,
    input wire [31:0]        rd_data_out,
    // transfer controller side
    input wire               tc_valid_out,
    input wire               tc_ready_in,
    input wire [1:0]         tc_chan_out,
    input wire [ENTRY_W-1:0] tc_entry_out,
    input wire [255:0]       tc_ctx_out,
    input wire               tc_done_in,
    input wire [1:0]         tc_done_chan_in
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (srst_in);

    offer_hold_a: assert property (
        tc_valid_out && !tc_ready_in |=> tc_valid_out &&
        $stable({tc_chan_out, tc_entry_out, tc_ctx_out}))
        else $error("request changed before accept");
    reread_gap_a: assert property (
        tc_valid_out && tc_ready_in |=> !tc_valid_out [*8])
        else $error("offer without fresh read");
    reset_quiet_a: assert property (
        $fell(srst_in) |-> !tc_valid_out [*8])
        else $error("offer with no trigger");
    rd_idle_a: assert property (
        !rd_in |=> rd_data_out == 32'h0000_0000)
        else $error("read data without a read");
    unmapped_a: assert property (
        rd_in && addr_in[ENTRY_W+3] && addr_in[3:0] > 4'h6 |=>
        rd_data_out == 32'h0000_0000)
        else $error("unmapped index nonzero");
    chan_bits_a: assert property (
        rd_in && addr_in[ENTRY_W+3] &&
        addr_in[3:0] inside {4'h4, 4'h5, 4'h6} |=>
        rd_data_out[31:4] == 28'h000_0000)
        else $error("status bits above four");
    map_field_a: assert property (
        rd_in && addr_in[ENTRY_W+3] && addr_in[3:2] == 2'b00 |=>
        rd_data_out[1:0] == 2'b00 && rd_data_out[31:ENTRY_W+5] == '0)
        else $error("map bits outside fields");
    readback_a: assert property (
        rd_in && !addr_in[ENTRY_W+3] && $past(wr_in, 2) &&
        !$past(wr_in) && $past(addr_in, 2) == addr_in |=>
        rd_data_out == $past(wr_data_in, 3))
        else $error("readback wrong");
endmodule

// ===== verif/qdl_tc_model.sv
// transfer controller model: takes requests, reports completion
// assumes stall_in high keeps requests waiting
`timescale 1ns/1ps
module qdl_tc_model #(
    parameter DONE_LAT = 4
) (
    // clock and reset
    input  wire       ref_clk_in,
    input  wire       srst_in,
    // request side
    input  wire       stall_in,
    input  wire       valid_in,
    input  wire [1:0] chan_in,
    output reg        ready_out,
    // completion side
    output reg        done_out,
    output reg  [1:0] done_chan_out
);
    reg [3:0] wait_reg;
    reg [1:0] chan_reg;
    always @(posedge ref_clk_in) begin
        done_out <= 1'b0;
        // idle channel lines toggle so stale values miss
        done_chan_out <= ~done_chan_out;
        if (srst_in) begin
            ready_out <= 1'b0;
            wait_reg <= 4'h0;
            done_chan_out <= 2'h0;
        end else begin
            ready_out <= valid_in && !ready_out && !stall_in;
            if (valid_in && ready_out) begin
                wait_reg <= DONE_LAT[3:0];
                chan_reg <= chan_in;
            end else if (wait_reg != 4'h0) begin
                wait_reg <= wait_reg - 4'h1;
            end
            if (wait_reg == 4'h1) begin
                done_out <= 1'b1;
                done_chan_out <= chan_reg;
            end
        end
    end
endmodule

// ===== verif/testbench.sv
// self-checking bench for the quick channel block
// assumes the controller model and checker files
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [1:0] ch;
        logic [6:0] ent;
        logic [2:0] tw;
    } qdl_row_t;
    qdl_row_t rows [8] = '{'{0, 3, 7}, '{1, 9, 0}, '{2, 17, 1},
        '{3, 33, 2}, '{0, 64, 3}, '{1, 100, 4}, '{2, 126, 5},
        '{3, 127, 6}};
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic [10:0]  addr = 11'h000;
    logic [31:0]  wdat = 32'h0000_0000;
    logic         wr = 1'b0;
    logic         rd = 1'b0;
    logic         stall = 1'b0;
    wire  [31:0]  rdat;
    wire          tv, tr, dn;
    wire  [1:0]   tch, dch;
    wire  [6:0]   tent;
    wire  [255:0] ctx;
    logic [1:0]   ach;
    logic [6:0]   aent;
    logic [255:0] actx;
    int           errors = 0;
    int           num_checks = 0;
    int           cyc = 0;

    qdl_quick_channel #(.ENTRY_W(7)) u_dut (
        .ref_clk_in(clk), .srst_in(rst), .ce_in(1'b1),
        .addr_in(addr), .wr_data_in(wdat), .wr_in(wr), .rd_in(rd),
        .rd_data_out(rdat), .tc_valid_out(tv), .tc_ready_in(tr),
        .tc_chan_out(tch), .tc_entry_out(tent), .tc_ctx_out(ctx),
        .tc_done_in(dn), .tc_done_chan_in(dch));
    qdl_tc_model u_tc (
        .ref_clk_in(clk), .srst_in(rst), .stall_in(stall),
        .valid_in(tv), .chan_in(tch), .ready_out(tr),
        .done_out(dn), .done_chan_out(dch));

    initial forever #10 clk = ~clk;

    // ****
    // helpers
    // ****
    function automatic logic [31:0] pat(logic [6:0] e, logic [2:0] w);
        pat = {9'h000, e, 13'h0000, w};
        if (w == 3'd0)
            pat = 32'h0000_0008;
        if (w == 3'd5)
            pat = {9'h000, e, 16'hFFFF};
    endfunction
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wrt(logic [10:0] a, logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdat <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdc(string n, logic [10:0] a, logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(n, rdat, e);
    endtask
    task automatic acc();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (!(tv === 1'b1 && tr === 1'b1) && k < 200);
        if (k == 200)
            chk("request offered", 32'h0, 32'h1);
        ach = tch;
        aent = tent;
        actx = ctx;
    endtask
    task automatic prog(logic [1:0] c, logic [6:0] e, logic [2:0] t);
        int w;
        wrt({9'h100, c}, {20'h0_0000, e, t, 2'b00});
        for (w = 0; w < 8; w++)
            if (w[2:0] != t)
                wrt({1'b0, e, w[2:0]}, pat(e, w[2:0]));
        rdc("pending early", 11'h404, 32'h0000_0000);
        wrt({1'b0, e, t}, pat(e, t));
    endtask

    // ****
    // main sequence
    // ****
    initial begin
        int i;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 4; i++)
            rdc("map reset", {9'h100, i[1:0]}, 32'h0000_001C);
        wrt(11'h404, 32'hFFFF_FFFF);
        rdc("pending ro", 11'h404, 32'h0000_0000);
        rdc("unmapped", 11'h40F, 32'h0000_0000);
        foreach (rows[i]) begin
            prog(rows[i].ch, rows[i].ent, rows[i].tw);
            rdc("trig word", {1'b0, rows[i].ent, rows[i].tw},
                pat(rows[i].ent, rows[i].tw));
            acc();
            chk("chan", ach, rows[i].ch);
            chk("entry", aent, rows[i].ent);
            chk("ctx", actx[32*rows[i].tw +: 32],
                pat(rows[i].ent, rows[i].tw));
        end
        // four channels queue; entry 43 rewritten meanwhile
        stall <= 1'b1;
        for (i = 0; i < 4; i++)
            prog(i[1:0], 7'd40 + i[6:0], 3'd7);
        rdc("queued", 11'h405, 32'h0000_000F);
        wrt({1'b0, 7'd43, 3'd1}, 32'hDEAD_BEEF);
        stall <= 1'b0;
        for (i = 0; i < 4; i++) begin
            acc();
            chk("order", ach, i[1:0]);
            chk("late ctx", actx[63:32], i == 3 ? 32'hDEAD_BEEF :
                pat(7'd40 + i[6:0], 3'd1));
        end
        rdc("sec clear", 11'h405, 32'h0000_0000);
        rdc("static", {1'b0, 7'd43, 3'd0}, 32'h0000_0008);
        // entry 10 links to entry 20, the chain end
        for (i = 0; i < 8; i++)
            wrt({1'b0, 7'd20, i[2:0]}, pat(7'd20, i[2:0]));
        wrt(11'h400, {20'h0_0000, 7'd10, 3'd7, 2'b00});
        wrt({1'b0, 7'd10, 3'd0}, 32'h0000_0000);
        wrt({1'b0, 7'd10, 3'd5}, 32'h0000_0280);
        wrt({1'b0, 7'd10, 3'd7}, pat(7'd10, 3'd7));
        acc();
        repeat (60) @(posedge clk);
        for (i = 0; i < 8; i++)
            rdc("reload", {1'b0, 7'd10, i[2:0]},
                pat(7'd20, i[2:0]));
        rdc("no retrigger", 11'h404, 32'h0000_0000);
        wrt({1'b0, 7'd20, 3'd1}, 32'h1234_5678);
        wrt({1'b0, 7'd10, 3'd7}, pat(7'd20, 3'd7));
        acc();
        repeat (60) @(posedge clk);
        rdc("chain end", {1'b0, 7'd10, 3'd1},
            pat(7'd20, 3'd1));
        rdc("done clear", 11'h406, 32'h0000_0000);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc("map rereset", 11'h400, 32'h0000_001C);
        end_of_test();
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            end_of_test();
        end
    end
endmodule

bind qdl_quick_channel qdl_qc_asserts #(.ENTRY_W(ENTRY_W)) u_chk (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .ce_in(ce_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
    .rd_in(rd_in), .rd_data_out(rd_data_out),
    .tc_valid_out(tc_valid_out), .tc_ready_in(tc_ready_in),
    .tc_chan_out(tc_chan_out), .tc_entry_out(tc_entry_out),
    .tc_ctx_out(tc_ctx_out), .tc_done_in(tc_done_in),
    .tc_done_chan_in(tc_done_chan_in));
